// *** hdl/reset_remap_regs.vh ***
`ifndef RESET_REMAP_REGS_VH
`define RESET_REMAP_REGS_VH

`define ADDR_BOOT_SEL   32'hFFFF0220
`define ADDR_CAUSE      32'hFFFF0230
`define ADDR_CAUSE_CLR  32'hFFFF0234
`define ADDR_UNLOCK1    32'hFFFF0248
`define ADDR_RET_CFG    32'hFFFF024C
`define ADDR_UNLOCK2    32'hFFFF0250
`define ADDR_IRQ_STAT   32'hFFFF0260
`define ADDR_IRQ_CLR    32'hFFFF0264
`define ADDR_IRQ_EN     32'hFFFF0268

`define KEY_FIRST       8'h76
`define KEY_SECOND      8'hB1

`define BIT_REMAP       0
`define BIT_POR         0
`define BIT_WDT         1
`define BIT_SW          2
`define CAUSE_MASK      8'h07
`define CAUSE_POR_RST   8'h01
`define RET_MASK        8'h05
`define BIT_RET_GPIO    0
`define BIT_RET_DAC     2

`define IRQ_N           4
`define IRQ_SW          0
`define IRQ_WDT         1
`define IRQ_BADCLR      2
`define IRQ_CFG         3

`define VEC_LO          32'h00000000
`define VEC_HI          32'h00000020

`define KERNEL_CYC      5'h10
`define RST_PULSE_CYC   4'h8

`endif

// *** hdl/vector_region_map.v ***
`timescale 1ns/1ps
`default_nettype none
`include "reset_remap_regs.vh"
module vector_region_map (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // fetch side
  input  wire [31:0] fetch_addr,
  input  wire        remap_sram,
  // decode result
  output reg         vec_hit_ff,
  output reg         to_sram_ff,
  output reg         to_flash_ff
);
  wire hit;

  assign hit = (fetch_addr >= `VEC_LO) && (fetch_addr <= `VEC_HI);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_hit_ff  <= 1'b0;
      to_sram_ff  <= 1'b0;
      to_flash_ff <= 1'b0;
    end else begin
      vec_hit_ff  <= hit;
      to_sram_ff  <= hit & remap_sram;
      to_flash_ff <= hit & ~remap_sram;
    end
  end
endmodule
`default_nettype wire

// *** hdl/retention_unlock.v ***
`timescale 1ns/1ps
`default_nettype none
`include "reset_remap_regs.vh"
module retention_unlock (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // decoded writes
  input  wire       wr_key1,
  input  wire       wr_value,
  input  wire       wr_key2,
  input  wire [7:0] wdata,
  // result
  output reg        accept_ff,
  output reg  [7:0] value_ff
);
  localparam S_IDLE = 3'h1;
  localparam S_KEY  = 3'h2;
  localparam S_VAL  = 3'h4;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg       nxt_accept;

  // writes to other registers do not break the sequence
  always @* begin
    nxt_state  = state_ff;
    nxt_accept = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (wr_key1 && wdata == `KEY_FIRST)
          nxt_state = S_KEY;
      end
      S_KEY: begin
        if (wr_value)
          nxt_state = S_VAL;
        else if (wr_key1 || wr_key2)
          nxt_state = (wr_key1 && wdata == `KEY_FIRST) ? S_KEY : S_IDLE;
      end
      S_VAL: begin
        if (wr_key2 && wdata == `KEY_SECOND)
          nxt_accept = 1'b1;
        if (wr_key1 || wr_key2 || wr_value)
          nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= S_IDLE;
      accept_ff <= 1'b0;
      value_ff  <= 8'h00;
    end else begin
      state_ff  <= nxt_state;
      accept_ff <= nxt_accept;
      if (state_ff == S_KEY && wr_value)
        value_ff <= wdata;
    end
  end
endmodule
`default_nettype wire

// *** hdl/reset_cause_and_boot_remap.v ***
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "reset_remap_regs.vh"
module reset_cause_and_boot_remap (
  // clock and resets
  input  wire        pclk,
  input  wire        presetn,
  input  wire        por_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  // reset sources and strap
  input  wire        wdt_timeout,
  input  wire        boot_select_pin,
  // core fetch decode
  input  wire [31:0] fetch_addr,
  output wire        vec_hit_ff,
  output wire        map_sram_ff,
  output wire        map_flash_ff,
  // boot and reset control
  output reg         remap_sram_ff,
  output reg         kernel_active_ff,
  output reg         user_start_ff,
  output reg         sys_reset_req_ff,
  // peripheral retention
  output reg         gpio_retain_ff,
  output reg         dac_retain_ff,
  // interrupt
  output reg         irq_ff
);
  localparam K_RUN  = 3'h1;
  localparam K_USER = 3'h2;
  localparam K_HOLD = 3'h4;

  function is_addr;
    input [31:0] a;
    input [31:0] r;
    begin
      is_addr = (a == r);
    end
  endfunction

  function is_mapped;
    input [31:0] a;
    begin
      is_mapped = is_addr(a, `ADDR_BOOT_SEL) | is_addr(a, `ADDR_CAUSE) |
                  is_addr(a, `ADDR_CAUSE_CLR) | is_addr(a, `ADDR_UNLOCK1) |
                  is_addr(a, `ADDR_RET_CFG) | is_addr(a, `ADDR_UNLOCK2) |
                  is_addr(a, `ADDR_IRQ_STAT) | is_addr(a, `ADDR_IRQ_CLR) |
                  is_addr(a, `ADDR_IRQ_EN);
    end
  endfunction

  // bus phases
  wire        setup;
  wire        acc;
  wire        wr;
  wire [7:0]  wbyte;
  reg  [31:0] nxt_rdata;

  assign setup = psel & ~penable;
  assign acc   = psel & penable & pready_ff;
  // registers are one byte wide, so only lane 0 carries a write
  assign wr    = acc & pwrite & pstrb[0] & ~pslverr_ff;
  assign wbyte = pwdata[7:0];

  // reset cause state, power-on domain
  reg  [7:0] cause_ff;
  reg  [7:0] nxt_cause;
  wire       clr_wr;
  wire [7:0] clr_bits;
  wire       sw_force;
  wire [7:0] set_bits;
  wire       bad_clear;

  // retention
  reg  [7:0] ret_cfg_ff;
  wire       cfg_accept;
  wire [7:0] cfg_value;

  // reset pulse
  reg  [3:0] rst_cnt_ff;
  reg  [3:0] nxt_rst_cnt;
  wire       rst_start;

  // kernel sequencer
  reg  [2:0] kstate_ff;
  reg  [2:0] nxt_kstate;
  reg  [4:0] kcnt_ff;

  // interrupts
  reg  [`IRQ_N-1:0] irq_en_ff;
  reg  [`IRQ_N-1:0] irq_stat_ff;
  wire [`IRQ_N-1:0] nxt_irq_stat;
  wire [`IRQ_N-1:0] irq_event;
  wire              irq_clr_wr;

  // apb answer: one access cycle, unmapped addresses flag an error
  always @* begin
    nxt_rdata = 32'h00000000;
    case (paddr)
      `ADDR_BOOT_SEL: nxt_rdata = {31'h00000000, remap_sram_ff};
      `ADDR_CAUSE:    nxt_rdata = {24'h000000, cause_ff & `CAUSE_MASK};
      `ADDR_RET_CFG:  nxt_rdata = {24'h000000, ret_cfg_ff};
      `ADDR_IRQ_STAT: nxt_rdata = {28'h0000000, irq_stat_ff};
      `ADDR_IRQ_EN:   nxt_rdata = {28'h0000000, irq_en_ff};
      `ADDR_CAUSE_CLR: nxt_rdata = 32'h00000000;
      default:        nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~is_mapped(paddr);
      if (setup && !pwrite)
        prdata_ff <= nxt_rdata;
      else if (acc)
        prdata_ff <= 32'h00000000;
    end
  end

  // boot region select: presetn covers every reset source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      remap_sram_ff <= 1'b0;
    else if (wr && is_addr(paddr, `ADDR_BOOT_SEL))
      remap_sram_ff <= wbyte[`BIT_REMAP];
  end

  vector_region_map u_map (
    .pclk        (pclk),
    .presetn     (presetn),
    .fetch_addr  (fetch_addr),
    .remap_sram  (remap_sram_ff),
    .vec_hit_ff  (vec_hit_ff),
    .to_sram_ff  (map_sram_ff),
    .to_flash_ff (map_flash_ff)
  );

  // reset cause flags
  assign clr_wr   = wr & is_addr(paddr, `ADDR_CAUSE_CLR);
  assign clr_bits = clr_wr ? (wbyte & `CAUSE_MASK) : 8'h00;
  assign sw_force = wr & is_addr(paddr, `ADDR_CAUSE) & wbyte[`BIT_SW];
  // only bit2 of the cause register is writable; 0 and 1 are hardware-set
  assign set_bits = {5'h00, sw_force, wdt_timeout, 1'b0};
  // a non-empty clear that leaves a set flag behind is treated as a fault
  assign bad_clear = clr_wr & (|clr_bits) &
                     (|(cause_ff & ~wbyte & `CAUSE_MASK));

  always @* begin
    // set wins over a clear in the same cycle
    nxt_cause = ((cause_ff & ~clr_bits) | set_bits) & `CAUSE_MASK;
  end

  // external pin reset only pulls presetn and records nothing here
  always @(posedge pclk or negedge por_n) begin
    if (!por_n)
      cause_ff <= `CAUSE_POR_RST;
    else
      cause_ff <= nxt_cause;
  end

  // forced reset request, held long enough for the reset controller
  assign rst_start = sw_force | bad_clear;

  always @* begin
    nxt_rst_cnt = rst_cnt_ff;
    if (rst_start)
      nxt_rst_cnt = `RST_PULSE_CYC;
    else if (rst_cnt_ff != 4'h0)
      nxt_rst_cnt = rst_cnt_ff - 4'h1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_ff       <= 4'h0;
      sys_reset_req_ff <= 1'b0;
    end else begin
      rst_cnt_ff       <= nxt_rst_cnt;
      sys_reset_req_ff <= (nxt_rst_cnt != 4'h0);
    end
  end

  // retention configuration, written only through the key sequence
  retention_unlock u_unlock (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_key1   (wr & is_addr(paddr, `ADDR_UNLOCK1)),
    .wr_value  (wr & is_addr(paddr, `ADDR_RET_CFG)),
    .wr_key2   (wr & is_addr(paddr, `ADDR_UNLOCK2)),
    .wdata     (wbyte),
    .accept_ff (cfg_accept),
    .value_ff  (cfg_value)
  );

  // survives watchdog and software resets; only power-on clears it
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      ret_cfg_ff     <= 8'h00;
      gpio_retain_ff <= 1'b0;
      dac_retain_ff  <= 1'b0;
    end else begin
      if (cfg_accept)
        ret_cfg_ff <= cfg_value & `RET_MASK;
      gpio_retain_ff <= ret_cfg_ff[`BIT_RET_GPIO] &
                        (cause_ff[`BIT_WDT] | cause_ff[`BIT_SW]);
      dac_retain_ff  <= ret_cfg_ff[`BIT_RET_DAC] &
                        (cause_ff[`BIT_WDT] | cause_ff[`BIT_SW]);
    end
  end

  // kernel phase after each reset; strap decides hand-over to user code
  always @* begin
    nxt_kstate = kstate_ff;
    case (kstate_ff)
      K_RUN: begin
        if (kcnt_ff == 5'h00)
          nxt_kstate = boot_select_pin ? K_USER : K_HOLD;
      end
      K_USER:  nxt_kstate = K_USER;
      K_HOLD:  nxt_kstate = K_HOLD;
      default: nxt_kstate = K_RUN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kstate_ff        <= K_RUN;
      kcnt_ff          <= `KERNEL_CYC;
      kernel_active_ff <= 1'b1;
      user_start_ff    <= 1'b0;
    end else begin
      kstate_ff <= nxt_kstate;
      if (kstate_ff == K_RUN && kcnt_ff != 5'h00)
        kcnt_ff <= kcnt_ff - 5'h01;
      kernel_active_ff <= (nxt_kstate != K_USER);
      // jump to vector zero, which decodes to flash after reset
      user_start_ff    <= (kstate_ff == K_RUN) && (nxt_kstate == K_USER);
    end
  end

  // interrupt status, enable and clear
  assign irq_event[`IRQ_SW]     = sw_force;
  assign irq_event[`IRQ_WDT]    = wdt_timeout;
  assign irq_event[`IRQ_BADCLR] = bad_clear;
  assign irq_event[`IRQ_CFG]    = cfg_accept;
  assign irq_clr_wr = wr & is_addr(paddr, `ADDR_IRQ_CLR);

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_N; gi = gi + 1) begin : g_irq
      assign nxt_irq_stat[gi] = irq_event[gi] |
                                (irq_stat_ff[gi] & ~(irq_clr_wr & wbyte[gi]));
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= {`IRQ_N{1'b0}};
      irq_en_ff   <= {`IRQ_N{1'b0}};
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr && is_addr(paddr, `ADDR_IRQ_EN))
        irq_en_ff <= wbyte[`IRQ_N-1:0];
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
    end
  end
endmodule
`default_nettype wire

// *** test/core_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
  // clock
  input  wire logic        pclk,
  // apb request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [31:0] paddr,
  output var  logic [31:0] pwdata,
  output var  logic [3:0]  pstrb,
  // apb answer
  input  wire logic [31:0] prdata_ff,
  input  wire logic        pready_ff,
  input  wire logic        pslverr_ff
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // one idle edge first, so back-to-back calls never drive psel twice per step
  task automatic xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_ff !== 1'b1);
    q = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep showing the old value
    paddr <= ~a;
    pwdata <= ~d;
    #1;
  endtask
endmodule
`default_nettype wire

// *** test/reset_cause_and_boot_remap_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "reset_remap_regs.vh"
module remap_checker (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // stimulus side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] fetch_addr,
  // design outputs
  input wire logic [31:0] prdata_ff,
  input wire logic        pready_ff,
  input wire logic        vec_hit_ff,
  input wire logic        map_sram_ff,
  input wire logic        map_flash_ff,
  input wire logic        remap_sram_ff,
  input wire logic        kernel_active_ff,
  input wire logic        user_start_ff,
  input wire logic        sys_reset_req_ff
);
  // edges since reset release, saturating
  logic [7:0] cyc_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cyc_ff <= 8'h00;
    else if (cyc_ff != 8'hFF)
      cyc_ff <= cyc_ff + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence read_s(a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence low_s(r);
    fetch_addr <= `VEC_HI && remap_sram_ff == r ##1 remap_sram_ff == r;
  endsequence
  a_ready_after_setup: assert property (psel && !penable |=> pready_ff)
    else $error("no ready after setup");
  a_clear_reads_zero: assert property (read_s(`ADDR_CAUSE_CLR) |=> prdata_ff == 32'h0)
    else $error("clear register read not zero");
  a_cause_reserved_zero: assert property (read_s(`ADDR_CAUSE) |=> prdata_ff[31:3] == 29'h0)
    else $error("reserved cause bits set");
  a_vector_hit: assert property (fetch_addr <= `VEC_HI |=> vec_hit_ff)
    else $error("vector region missed");
  a_sram_map: assert property (low_s(1'b1) |-> map_sram_ff && !map_flash_ff)
    else $error("sram not mapped low");
  a_flash_map: assert property (low_s(1'b0) |-> map_flash_ff && !map_sram_ff)
    else $error("flash not mapped low");
  a_remap_cleared: assert property ($rose(presetn) |-> !remap_sram_ff)
    else $error("remap kept over reset");
  a_handover_time: assert property (user_start_ff |-> cyc_ff == 8'd17 && !kernel_active_ff)
    else $error("user start at wrong time");
  a_reset_pulse_len: assert property ($rose(sys_reset_req_ff) |-> sys_reset_req_ff[*8] ##1 !sys_reset_req_ff)
    else $error("reset request length wrong");
endmodule
bind reset_cause_and_boot_remap remap_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .fetch_addr(fetch_addr), .prdata_ff(prdata_ff),
  .pready_ff(pready_ff), .vec_hit_ff(vec_hit_ff), .map_sram_ff(map_sram_ff), .map_flash_ff(map_flash_ff),
  .remap_sram_ff(remap_sram_ff), .kernel_active_ff(kernel_active_ff), .user_start_ff(user_start_ff),
  .sys_reset_req_ff(sys_reset_req_ff));
`default_nettype wire

// *** test/reset_cause_and_boot_remap_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "reset_remap_regs.vh"
module reset_cause_and_boot_remap_bench;
  logic        pclk;
  logic        presetn;
  logic        por_n;
  logic        wdt_timeout;
  logic        boot_select_pin;
  logic [31:0] fetch_addr;
  wire logic   psel, penable, pwrite, pready_ff, pslverr_ff, vec_hit_ff, map_sram_ff, map_flash_ff;
  wire logic   remap_sram_ff, kernel_active_ff, user_start_ff, sys_reset_req_ff;
  wire logic   gpio_retain_ff, dac_retain_ff, irq_ff;
  wire logic [31:0] paddr, pwdata, prdata_ff;
  wire logic [3:0]  pstrb;
  int miscompares = 0;
  int check_count = 0;
  always #2.5 pclk = ~pclk;
  core_bus_model bus (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff));
  reset_cause_and_boot_remap dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .wdt_timeout(wdt_timeout),
    .boot_select_pin(boot_select_pin), .fetch_addr(fetch_addr), .vec_hit_ff(vec_hit_ff),
    .map_sram_ff(map_sram_ff), .map_flash_ff(map_flash_ff), .remap_sram_ff(remap_sram_ff),
    .kernel_active_ff(kernel_active_ff), .user_start_ff(user_start_ff),
    .sys_reset_req_ff(sys_reset_req_ff), .gpio_retain_ff(gpio_retain_ff),
    .dac_retain_ff(dac_retain_ff), .irq_ff(irq_ff));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] q;
    logic        e;
    bus.xfer(1'b1, a, d, s, q, e);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    bus.xfer(1'b0, a, 32'h0, 4'hF, q, e);
    chk($sformatf("read %h", a), x, q);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic fetch(input logic [31:0] a);
    @(posedge pclk);
    fetch_addr <= a;
    settle();
  endtask
  // 20 edges covers the kernel hand-over after release
  task automatic rst(input logic por);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= !por;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    repeat (20) @(posedge pclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // whole run is well under 2000 cycles
  initial begin
    #20us;
    miscompares++;
    report_and_stop();
  end
  initial begin
    logic [31:0] q;
    logic        e;
    pclk = 1'b0;
    presetn = 1'b0;
    por_n = 1'b0;
    wdt_timeout = 1'b0;
    boot_select_pin = 1'b1;
    fetch_addr = 32'h00080100;
    rst(1'b1);
    chk("kernel", 0, kernel_active_ff);
    rd(`ADDR_BOOT_SEL, 0);
    rd(`ADDR_CAUSE, `CAUSE_POR_RST);
    rd(`ADDR_CAUSE_CLR, 0);
    bus.xfer(1'b0, 32'hFFFF0300, 32'h0, 4'hF, q, e);
    chk("slverr", 1, e);
    $display("reset values done");
    wr(`ADDR_BOOT_SEL, 1, 4'hE);
    chk("remap", 0, remap_sram_ff);
    wr(`ADDR_BOOT_SEL, 1);
    chk("remap", 1, remap_sram_ff);
    fetch(`VEC_HI);
    chk("sram map", 1, map_sram_ff);
    fetch(32'h00080100);
    wr(`ADDR_BOOT_SEL, 0);
    fetch(`VEC_LO);
    chk("flash map", 1, map_flash_ff);
    fetch(32'h00000024);
    chk("hit", 0, vec_hit_ff);
    fetch(32'h00080100);
    $display("remap done");
    wr(`ADDR_CAUSE_CLR, 0);
    rd(`ADDR_CAUSE, 1);
    wr(`ADDR_CAUSE, 3);
    rd(`ADDR_CAUSE, 1);
    wr(`ADDR_CAUSE_CLR, 1);
    rd(`ADDR_CAUSE, 0);
    chk("reset req", 0, sys_reset_req_ff);
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    rd(`ADDR_CAUSE, 2);
    rd(`ADDR_IRQ_STAT, 2);
    chk("irq masked", 0, irq_ff);
    wr(`ADDR_IRQ_EN, 2);
    settle();
    chk("irq", 1, irq_ff);
    wr(`ADDR_IRQ_CLR, 2);
    settle();
    chk("irq cleared", 0, irq_ff);
    $display("causes and irq done");
    wr(`ADDR_RET_CFG, 5);
    rd(`ADDR_RET_CFG, 0);
    wr(`ADDR_UNLOCK1, `KEY_FIRST);
    wr(`ADDR_RET_CFG, 5);
    wr(`ADDR_UNLOCK2, `KEY_SECOND);
    settle();
    rd(`ADDR_RET_CFG, 5);
    chk("gpio keep", 1, gpio_retain_ff);
    chk("dac keep", 1, dac_retain_ff);
    wr(`ADDR_UNLOCK1, `KEY_FIRST);
    wr(`ADDR_RET_CFG, 4);
    wr(`ADDR_UNLOCK2, 32'h000000B0);
    settle();
    rd(`ADDR_RET_CFG, 5);
    $display("retention done");
    wr(`ADDR_BOOT_SEL, 1);
    wr(`ADDR_CAUSE_CLR, 4);
    settle();
    chk("reset req", 1, sys_reset_req_ff);
    rst(1'b0);
    rd(`ADDR_BOOT_SEL, 0);
    rd(`ADDR_CAUSE, 2);
    wr(`ADDR_CAUSE, 4);
    settle();
    chk("reset req", 1, sys_reset_req_ff);
    rst(1'b0);
    rd(`ADDR_CAUSE, 6);
    chk("gpio keep", 1, gpio_retain_ff);
    wr(`ADDR_CAUSE_CLR, 6);
    settle();
    chk("reset req", 0, sys_reset_req_ff);
    rd(`ADDR_CAUSE, 0);
    chk("gpio keep", 0, gpio_retain_ff);
    @(posedge pclk);
    boot_select_pin <= 1'b0;
    rst(1'b1);
    chk("kernel hold", 1, kernel_active_ff);
    chk("no user start", 0, user_start_ff);
    rd(`ADDR_RET_CFG, 0);
    $display("forced resets done");
    report_and_stop();
  end
endmodule
`default_nettype wire
